//--- logic/sbo_options.sv
/*
  Node capability options register with AHB-Lite slave access, generation
  counter, software reset handling and block request size check.
  Assumes nrst is the global hardware reset, all other inputs are
  synchronous to clk_sys, and the bus has this one slave.
*/
// The AHB-Lite slave port and the address map were left to the implementer.
// What this block does
// RULE_01: Bits 31-28 writable capability flags, read back
// RULE_02: Bit 27 writable power-management capable flag
// RULE_03: Software keeps fields valid while link enabled
// RULE_04: Reserved bits read zero, writes ignored
// RULE_05: Bits 23-16 writable clock accuracy in ppm
// RULE_06: Bits 15-12 request-size code, limit at least 512
// RULE_07: Oversized block write may give type error
// RULE_08: Hardware reset sets 2048 code, soft keeps
// RULE_09: Bits 7-6 generation counter, bumps on ROM change
// RULE_10: Bits 2-0 read-only, always binary 010
// RULE_11: Some bits cleared only by hardware reset
module sbo_options #(
  parameter int ADDR_W = 32,
  parameter int LEN_W = sbo_pkg::LEN_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic soft_reset,
  input wire logic link_enable_control,
  input wire logic bus_reset,
  input wire logic rom_changed,
  input wire logic blk_wr_valid,
  input wire logic [LEN_W-1:0] blk_wr_len,
  output logic ack_type_error,
  output logic [31:0] node_options,
  output logic [sbo_pkg::NUM_FLAGS-1:0] cap_flags,
  output logic [7:0] clk_accuracy,
  output logic [3:0] max_req_code,
  output logic [1:0] generation
);

  // Bus phase tracking
  sbo_pkg::sbo_phase_t phase_q;
  sbo_pkg::sbo_phase_t phase_d;
  logic addr_hit;
  logic word_size;
  logic take_req;
  logic take_write;
  logic take_read;
  logic wr_now;

  // Register fields
  logic [sbo_pkg::NUM_FLAGS-1:0] flags_q;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [3:0] rec_q;
  logic [3:0] rec_d;
  logic [1:0] gen_q;
  logic [1:0] gen_d;
  logic dirty_q;
  logic dirty_d;
  logic rec_wr_ok;
  logic gen_bump;

  // Read path
  logic [31:0] word_d;
  logic [31:0] word_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [31:0] wr_masked;

  // Address phase decode
  assign addr_hit = hsel && (haddr == ADDR_W'(sbo_pkg::OPT_OFFSET));
  assign word_size = (hsize == sbo_pkg::HSIZE_WORD);
  assign take_req = hsel && hready && (htrans == sbo_pkg::HTRANS_NONSEQ);
  assign take_write = take_req && hwrite && addr_hit && word_size;
  assign take_read = take_req && !hwrite;

  always_comb
  begin
    phase_d = sbo_pkg::PH_IDLE;
    if (take_write)
    begin
      phase_d = sbo_pkg::PH_WRITE;
    end
    else if (take_read)
    begin
      phase_d = sbo_pkg::PH_READ;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_q <= sbo_pkg::PH_IDLE;
    end
    else
    begin
      phase_q <= phase_d;
    end
  end

  // Data phase write strobe; hwdata is valid in this cycle
  always_comb
  begin
    case (phase_q)
      sbo_pkg::PH_WRITE: wr_now = 1'b1;
      sbo_pkg::PH_READ: wr_now = 1'b0;
      sbo_pkg::PH_IDLE: wr_now = 1'b0;
      default: wr_now = 1'b0;
    endcase
  end

  assign wr_masked = hwdata & sbo_pkg::WRITE_MASK; // RULE_04

  // Capability flags, one flip-flop per bit
  genvar gi;
  generate
    for (gi = 0; gi < sbo_pkg::NUM_FLAGS; gi++)
    begin : g_flag
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          flags_q[gi] <= 1'b0;
        end
        else if (soft_reset)
        begin
          flags_q[gi] <= 1'b0;
        end
        else if (wr_now)
        begin
          flags_q[gi] <= wr_masked[sbo_pkg::FLAG_LO + gi]; // RULE_01 RULE_02
        end
      end
    end
  endgenerate

  // Clock accuracy field
  assign acc_d = soft_reset ? sbo_pkg::ACC_RST :
                 wr_now ? wr_masked[sbo_pkg::ACC_HI:sbo_pkg::ACC_LO] : // RULE_05
                 acc_q;

  // Request-size code: codes below the 512-byte minimum are not taken
  assign rec_wr_ok = wr_masked[sbo_pkg::REC_HI:sbo_pkg::REC_LO] >= sbo_pkg::REC_MIN; // RULE_06
  assign rec_d = (wr_now && rec_wr_ok) ? wr_masked[sbo_pkg::REC_HI:sbo_pkg::REC_LO] : rec_q;

  // Generation counter steps once on a bus reset that follows one or more ROM changes
  assign dirty_d = soft_reset ? 1'b0 : (rom_changed || (dirty_q && !bus_reset)); // RULE_09
  assign gen_bump = bus_reset && dirty_q; // RULE_09
  assign gen_d = soft_reset ? sbo_pkg::GEN_RST :
                 wr_now ? wr_masked[sbo_pkg::GEN_HI:sbo_pkg::GEN_LO] :
                 gen_bump ? gen_q + sbo_pkg::GEN_STEP : // RULE_09
                 gen_q;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_q <= sbo_pkg::ACC_RST;
      gen_q <= sbo_pkg::GEN_RST;
      dirty_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      gen_q <= gen_d;
      dirty_q <= dirty_d;
    end
  end

  // Request-size code: only the global hardware reset restores it
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rec_q <= sbo_pkg::REC_RST; // RULE_08 RULE_11
    end
    else
    begin
      rec_q <= rec_d; // RULE_08
    end
  end

  // Next register word, so a read right after a write sees new data
  always_comb
  begin
    word_d = 32'h0000_0000; // RULE_04
    word_d[sbo_pkg::FLAG_HI:sbo_pkg::FLAG_LO] = soft_reset ? '0 :
      (wr_now ? wr_masked[sbo_pkg::FLAG_HI:sbo_pkg::FLAG_LO] : flags_q);
    word_d[sbo_pkg::ACC_HI:sbo_pkg::ACC_LO] = acc_d;
    word_d[sbo_pkg::REC_HI:sbo_pkg::REC_LO] = rec_d;
    word_d[sbo_pkg::GEN_HI:sbo_pkg::GEN_LO] = gen_d;
    word_d[sbo_pkg::SPD_HI:sbo_pkg::SPD_LO] = sbo_pkg::LINK_SPEED; // RULE_10
  end

  // Unmapped reads return zero
  assign rdata_d = (take_read && addr_hit) ? word_d : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= 32'h0000_0000;
      word_q <= {29'h0000_0000, sbo_pkg::LINK_SPEED} |
                {16'h0000, sbo_pkg::REC_RST, 12'h000};
    end
    else
    begin
      if (take_read)
      begin
        rdata_q <= rdata_d;
      end
      word_q <= word_d;
    end
  end

  // Block write length check, active only while the link is enabled
  sbo_req_limit #(
    .LEN_W(LEN_W)
  ) u_req_limit (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .check_en(link_enable_control), // RULE_03
    .size_code(rec_q),
    .req_valid(blk_wr_valid),
    .req_len(blk_wr_len),
    .too_long(ack_type_error) // RULE_07
  );

  // Bus answers: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = sbo_pkg::HRESP_OKAY;
  assign hrdata = rdata_q;

  // Field views for the link layer
  assign node_options = word_q;
  assign cap_flags = word_q[sbo_pkg::FLAG_HI:sbo_pkg::FLAG_LO];
  assign clk_accuracy = word_q[sbo_pkg::ACC_HI:sbo_pkg::ACC_LO];
  assign max_req_code = word_q[sbo_pkg::REC_HI:sbo_pkg::REC_LO];
  assign generation = word_q[sbo_pkg::GEN_HI:sbo_pkg::GEN_LO];

endmodule // sbo_options

//--- logic/sbo_pkg.sv
/*
  Constants for the node capability options register: bus offset, field
  positions, reset values and bus encodings.
  Assumes a 32-bit AHB-Lite register bus and one 200 MHz system clock.
*/
package sbo_pkg;

  // Byte address of the node capability options register
  localparam logic [31:0] OPT_OFFSET = 32'h0000_0020;

  // Field positions
  localparam int FLAG_HI = 31;
  localparam int FLAG_LO = 27;
  localparam int NUM_FLAGS = 5;
  localparam int ACC_HI = 23;
  localparam int ACC_LO = 16;
  localparam int REC_HI = 15;
  localparam int REC_LO = 12;
  localparam int GEN_HI = 7;
  localparam int GEN_LO = 6;
  localparam int SPD_HI = 2;
  localparam int SPD_LO = 0;

  // Bits that software may write; all others read back constant
  localparam logic [31:0] WRITE_MASK = 32'hf8ff_f0c0;

  // Reset and fixed values
  localparam logic [3:0] REC_RST = 4'ha;
  localparam logic [3:0] REC_MIN = 4'h8;
  localparam logic [2:0] LINK_SPEED = 3'h2;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [1:0] GEN_RST = 2'h0;
  localparam logic [1:0] GEN_STEP = 2'h1;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Block request length width
  localparam int LEN_W = 16;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ
  } sbo_phase_t;

endpackage

//--- logic/sbo_req_limit.sv
/*
  Block write length check against the request-size code.
  Assumes request strobes synchronous to clk_sys.
*/
module sbo_req_limit #(
  parameter int LEN_W = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic check_en,
  input wire logic [3:0] size_code,
  input wire logic req_valid,
  input wire logic [LEN_W-1:0] req_len,
  output logic too_long
);

  logic [LEN_W+1:0] limit_bytes;
  logic [LEN_W+1:0] len_ext;
  logic over;
  logic too_long_q;

  // Limit is two to the power of code plus one
  assign limit_bytes = (LEN_W+2)'(1) << ({1'b0, size_code} + 5'h01);
  assign len_ext = {2'h0, req_len};
  assign over = req_valid && check_en && (len_ext > limit_bytes);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      too_long_q <= 1'b0;
    end
    else
    begin
      too_long_q <= over; // RULE_07
    end
  end

  assign too_long = too_long_q;

endmodule // sbo_req_limit

//--- tb/sbo_options_checker.sv
/*
  Port assertions for the node capability options register.
  Assumes it is bound to sbo_options and that hready follows hreadyout.
*/
module sbo_options_checker #(
  parameter int ADDR_W = 32,
  parameter int LEN_W = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic soft_reset,
  input wire logic link_enable_control,
  input wire logic bus_reset,
  input wire logic rom_changed,
  input wire logic blk_wr_valid,
  input wire logic [LEN_W-1:0] blk_wr_len,
  input wire logic ack_type_error,
  input wire logic [31:0] node_options
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence s_wr;
    hsel && hready && htrans == sbo_pkg::HTRANS_NONSEQ && hwrite
      && hsize == sbo_pkg::HSIZE_WORD && haddr == sbo_pkg::OPT_OFFSET;
  endsequence
  sequence s_len;
    (blk_wr_valid && link_enable_control) ##1 $stable(node_options[15:12]);
  endsequence
  sequence s_gen;
    !hsel ##1 (rom_changed && !hsel && !soft_reset)
      ##1 (bus_reset && !hsel && !soft_reset) ##1 !soft_reset;
  endsequence
  a_spd_fixed: assert property (node_options[2:0] == sbo_pkg::LINK_SPEED)
    else $error("link speed field wrong");
  a_rsvd_zero: assert property ((node_options & 32'h0700_0f38) == 32'h0)
    else $error("reserved bits not zero");
  a_rec_min: assert property (node_options[15:12] >= sbo_pkg::REC_MIN)
    else $error("request size code below minimum");
  a_len_check: assert property (s_len |-> ack_type_error ==
    (32'($past(blk_wr_len)) > (32'h1 << (node_options[15:12] + 5'h1))))
    else $error("length error flag wrong");
  a_len_quiet: assert property (!(blk_wr_valid && link_enable_control) |=> !ack_type_error)
    else $error("length error without request");
  a_soft_keep: assert property (!hsel [*4] ##1 soft_reset |->
    ##2 node_options[15:12] == $past(node_options[15:12], 3))
    else $error("request size changed by soft reset");
  a_gen_bump: assert property (s_gen |->
    ##1 node_options[7:6] == 2'($past(node_options[7:6], 2) + 2'h1))
    else $error("generation did not step");
  a_write_back: assert property (s_wr ##1 !soft_reset |-> ##2
    (node_options[31:27] == $past(hwdata[31:27], 2)
      && node_options[23:16] == $past(hwdata[23:16], 2)))
    else $error("written fields not stored");
endmodule // sbo_options_checker

bind sbo_options sbo_options_checker #(.ADDR_W(ADDR_W), .LEN_W(LEN_W)) u_sbo_options_checker (
  .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .soft_reset(soft_reset), .link_enable_control(link_enable_control),
  .bus_reset(bus_reset), .rom_changed(rom_changed), .blk_wr_valid(blk_wr_valid),
  .blk_wr_len(blk_wr_len), .ack_type_error(ack_type_error), .node_options(node_options));

//--- tb/tb_sbo_options.sv
/*
  Testbench for the node capability options register over AHB-Lite.
  Assumes one 200 MHz clock and hready looped back from hreadyout.
*/
module tb_sbo_options;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] OFF = sbo_pkg::OPT_OFFSET;
  logic clk_sys, nrst, hsel, hwrite, hrdy, link_en, blk_v, ack;
  logic [31:0] haddr, hwdata, hrdata, rd_v;
  logic [1:0] htrans;
  logic [2:0] ev;
  logic [2:0] hsz;
  logic hresp;
  logic [31:0] nopt;
  logic [4:0] cap;
  logic [7:0] acc;
  logic [3:0] code;
  logic [1:0] gen;
  logic [15:0] blk_len;
  int errors = 0;
  int n_checks = 0;

  sbo_options u_sbo_options (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsz), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .soft_reset(ev[2]),
    .link_enable_control(link_en), .bus_reset(ev[1]), .rom_changed(ev[0]),
    .blk_wr_valid(blk_v), .blk_wr_len(blk_len), .ack_type_error(ack), .node_options(nopt),
    .cap_flags(cap), .clk_accuracy(acc), .max_req_code(code), .generation(gen));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for hready high at a rising edge, bounded
  task wt;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk_sys);
      if (hrdy === 1'b1)
        return;
    end
    errors++;
    end_of_test();
  endtask

  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= sbo_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd_v = hrdata;
  endtask

  task rc(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_v, exp);
    chk({31'h0, hresp}, {31'h0, sbo_pkg::HRESP_OKAY});
    if (a == OFF)
    begin
      chk(nopt, exp);
      chk({13'h0, cap, acc, code, gen}, {13'h0, exp[31:27], exp[23:16], exp[15:12], exp[7:6]});
    end
  endtask

  // Quiet bus, then two event cycles {soft, bus reset, rom change}
  task ev_seq(input logic [2:0] a, input logic [2:0] b);
    repeat (4) @(posedge clk_sys);
    ev <= a;
    @(posedge clk_sys);
    ev <= b;
    @(posedge clk_sys);
    ev <= 3'h0;
  endtask

  task pk(input logic [15:0] len, input logic exp);
    @(posedge clk_sys);
    blk_v <= 1'b1;
    blk_len <= len;
    @(posedge clk_sys);
    blk_v <= 1'b0;
    #1;
    chk({31'h0, ack}, {31'h0, exp});
  endtask

  task hw_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask

  initial
  begin
    nrst = 1'b0;
    {hsel, hwrite, link_en, blk_v} = 4'h0;
    {haddr, hwdata, htrans, ev, blk_len} = '0;
    hsz = sbo_pkg::HSIZE_WORD;
    hw_reset();
    rc(OFF, 32'h0000_a002);
    xfer(1'b1, OFF, 32'hffff_ffff);
    rc(OFF, 32'hf8ff_f0c2);
    xfer(1'b1, OFF, 32'h0000_7000);
    rc(OFF, 32'h0000_f002);
    xfer(1'b1, OFF, 32'h0000_a0c0);
    ev_seq(3'h1, 3'h2);
    rc(OFF, 32'h0000_a002);
    ev_seq(3'h1, 3'h2);
    ev_seq(3'h2, 3'h0);
    rc(OFF, 32'h0000_a042);
    link_en <= 1'b1;
    pk(16'h0801, 1'b1);
    pk(16'h0800, 1'b0);
    xfer(1'b1, OFF, 32'h0000_8000);
    pk(16'h0201, 1'b1);
    pk(16'h0200, 1'b0);
    link_en <= 1'b0;
    pk(16'h1001, 1'b0);
    xfer(1'b1, OFF, 32'h58ab_b040);
    ev_seq(3'h4, 3'h0);
    rc(OFF, 32'h0000_b002);
    xfer(1'b1, 32'h0000_0024, 32'hffff_ffff);
    rc(32'h0000_0024, 32'h0);
    hsz <= 3'h1;
    xfer(1'b1, OFF, 32'hffff_ffff);
    hsz <= sbo_pkg::HSIZE_WORD;
    rc(OFF, 32'h0000_b002);
    hw_reset();
    rc(OFF, 32'h0000_a002);
    end_of_test();
  end
endmodule // tb_sbo_options
